/* pkg/flash_erase_pkg.sv */
// Shared constants for the serial flash erase link and its host controller
package flash_erase_pkg;
   // ****************************************
   // Command opcodes
   // ****************************************
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] STATUS_ONE_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_TWO_READ_CMD = 8'h07;
   localparam logic [7:0] STATUS_CONFIG_WRITE_CMD = 8'h01;
   localparam logic [7:0] BANK_REG_ACCESS_CMD = 8'hb9;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] PROGRAM_CMD = 8'h02;
   localparam logic [7:0] PROGRAM_4BYTE_CMD = 8'h12;
   localparam logic [7:0] PARAM_SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] PARAM_SECTOR_ERASE_4BYTE_CMD = 8'h21;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
   localparam logic [7:0] SECTOR_ERASE_4BYTE_CMD = 8'hdc;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'h60;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_ALT_CMD = 8'hc7;
   localparam logic [7:0] ERASE_PAUSE_CMD = 8'h75;
   localparam logic [7:0] ERASE_CONTINUE_CMD = 8'h7a;
   localparam logic [7:0] PERSIST_PROTECT_ERASE_CMD = 8'he4;
   // ****************************************
   // Status fields, data values and timing
   // ****************************************
   localparam int WIP_POS = 0;
   localparam int WEL_POS = 1;
   localparam int BP_LSB = 2;
   localparam int ERASE_ERR_POS = 5;
   localparam int PROG_ERR_POS = 6;
   localparam int ERASE_SUSP_POS = 1;
   localparam int FOUR_BYTE_POS = 7;
   localparam logic [7:0] UNDEF_DATA = 8'h5a;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SUSPEND_LATENCY_NS = 1000;
   localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************
   // Host controller register map
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] WDATA_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam int CTRL_ABYTES_LSB = 8;
   localparam int CTRL_WBYTE_POS = 11;
   localparam int CTRL_RBYTE_POS = 12;
   localparam int STATUS_BUSY_POS = 0;
   localparam int STATUS_RDATA_LSB = 8;
endpackage

/* pkg/flash_link_if.sv */
// Serial flash link between host controller and device
`timescale 1ns/1ns
interface flash_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   modport device(input cs_n, input sck, input si, output so);
   modport host(output cs_n, output sck, output si, input so);
endinterface

/* core/flash_erase_device.sv */
// Serial flash device end: command decode, protection checks, erase engine
`timescale 1ns/1ns
// How it works
// (RULE_01) Param erase ignored in uniform 256k option
// (RULE_02) Param erase clears one 4k sector, needs latch
// (RULE_03) 20h follows address mode, 21h four bytes
// (RULE_04) Chip select must rise after last address bit
// (RULE_05) Erase starts at chip select rise, busy shown
// (RULE_06) Protected param sector: no erase, error set
// (RULE_07) Param erase on large sector: silently ignored
// (RULE_08) D8h by mode, DCh four bytes, needs latch
// (RULE_09) Protected sector erase: no erase, error set
// (RULE_10) Sector size fixed at 64k or 256k
// (RULE_11) Any protected sub-range refuses sector erase
// (RULE_12) Whole erase: 60h/C7h, latch, eight bits only
// (RULE_13) Whole erase needs block protect zero, no error
// (RULE_14) Whole erase skips protected sectors silently
// (RULE_15) Pause only for sector erase, within latency
// (RULE_16) Pause drops busy, suspended bit tells outcome
// (RULE_17) Continue ignored unless an erase is paused
// (RULE_18) Valid continue sets busy, later ones ignored
// (RULE_19) Reads inside paused sector return undefined data
// (RULE_20) Config write rejected while paused, except bank
// (RULE_21) Program into paused sector fails, error set
// (RULE_22) Host leaves resume gaps for erase to finish; the host controller enforces no resume gap, only a half-period chip select high between frames
// (RULE_23) Program error flag sits at status bit 6
// (RULE_24) Erase without write latch is dropped quietly
module flash_erase_device #(
   parameter int NR = 256,
   parameter bit UNIFORM_256K = 1'b0,
   parameter int ERASE_CYC = 2000,
   parameter int PROG_CYC = 200
) (
   input logic pclk,
   input logic presetn,
   flash_link_if.device link,
   input logic [NR-1:0] ppb_bits,
   input logic [NR-1:0] dyb_bits,
   input logic [31:0] param_prot_bits,
   input logic [7:0] mem_rd_data,
   output logic [31:0] mem_rd_addr_r,
   output logic erase_go_r,
   output logic [1:0] erase_kind_r,
   output logic [31:0] erase_addr_r,
   output logic [NR-1:0] erase_skip_r,
   output logic erase_done_r,
   output logic ppb_erase_go_r,
   output logic [15:0] status_r
);
   import flash_erase_pkg::*;
   localparam int IW = $clog2(NR);
   localparam logic [1:0] KIND_PARAM = 2'h1;
   localparam logic [1:0] KIND_SECTOR = 2'h2;
   localparam logic [1:0] KIND_WHOLE = 2'h3;
   if (NR < 4 || (1 << IW) != NR) $error("NR must be a power of two of at least 4");

   typedef enum {ENG_IDLE, ENG_ERASE, ENG_PAUSING, ENG_PAUSED, ENG_PROG, ENG_PAUSED_PROG} eng_state_type;
   eng_state_type state_r;
   logic [2:0] sync1_r, sync2_r;
   logic sck_prev_r, cs_prev_r;
   logic [6:0] cnt_r;
   logic [7:0] op_r, prev_op_r, out_sh_r, bank_reg_r;
   logic so_r;
   logic [31:0] sh_r, addr_r, erase_left_r, prog_left_r, pause_left_r;
   logic wel_r, eerr_r, perr_r, esus_r;
   logic [2:0] bp_r;
   logic cs_high, sck_rise, sck_fall, cs_rise, write_in_progress_flag;
   logic [6:0] abits;
   logic [IW-1:0] idx;
   logic in_paused, se_prot, p4_prot, addr_done;
   logic [7:0] sr1, sr2;

   // ****************************************
   // Pin synchronisers and edge detection
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 3'h4;
         sync2_r <= 3'h4;
         sck_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
      end else begin
         sync1_r <= {link.cs_n, link.sck, link.si};
         sync2_r <= sync1_r;
         sck_prev_r <= sync2_r[1];
         cs_prev_r <= sync2_r[2];
      end
   end
   assign cs_high = sync2_r[2];
   assign sck_rise = !cs_high && sync2_r[1] && !sck_prev_r;
   assign sck_fall = !cs_high && !sync2_r[1] && sck_prev_r;
   assign cs_rise = cs_high && !cs_prev_r;

   function automatic logic [6:0] addr_bits(input logic [7:0] op);
      if (op == PARAM_SECTOR_ERASE_4BYTE_CMD || op == SECTOR_ERASE_4BYTE_CMD || op == PROGRAM_4BYTE_CMD)
         return 7'd32; // see RULE_03 see RULE_08
      if (op == PARAM_SECTOR_ERASE_CMD || op == SECTOR_ERASE_CMD || op == PROGRAM_CMD || op == ARRAY_READ_CMD)
         return bank_reg_r[FOUR_BYTE_POS] ? 7'd32 : 7'd24; // see RULE_03 see RULE_08
      return 7'd0;
   endfunction

   function automatic logic range_prot(input logic [IW-1:0] i);
      logic bp_hit;
      bp_hit = (bp_r != 3'h0) && (int'(i) >= NR - (NR >> (3'h7 - bp_r)));
      return ppb_bits[i] | dyb_bits[i] | bp_hit;
   endfunction

   function automatic logic same_sector(input logic [31:0] a);
      if (erase_kind_r == KIND_PARAM)
         return a[31:12] == erase_addr_r[31:12];
      if (UNIFORM_256K)
         return a[31:18] == erase_addr_r[31:18];
      return a[31:16] == erase_addr_r[31:16];
   endfunction

   // ****************************************
   // Frame shifter
   // ****************************************
   assign abits = addr_bits(op_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 7'h0;
         sh_r <= 32'h0;
         op_r <= 8'h0;
         addr_r <= 32'h0;
         prev_op_r <= 8'h0;
      end else begin
         if (cs_high) begin
            cnt_r <= 7'h0;
         end else if (sck_rise) begin
            if (cnt_r != 7'h7f) begin
               cnt_r <= cnt_r + 7'h1;
            end
            sh_r <= {sh_r[30:0], sync2_r[0]};
            if (cnt_r == 7'd7) begin
               op_r <= {sh_r[6:0], sync2_r[0]};
            end
            if (abits != 7'h0 && cnt_r == abits + 7'd7) begin
               addr_r <= (abits == 7'd32) ? {sh_r[30:0], sync2_r[0]} : {8'h0, sh_r[22:0], sync2_r[0]};
            end
         end
         if (cs_rise && cnt_r >= 7'd8) begin
            prev_op_r <= op_r;
         end
      end
   end

   // ****************************************
   // Serial output: status and array reads
   // ****************************************
   assign write_in_progress_flag = state_r inside {ENG_ERASE, ENG_PAUSING, ENG_PROG, ENG_PAUSED_PROG};
   assign sr1 = {1'b0, perr_r, eerr_r, bp_r, wel_r, write_in_progress_flag}; // see RULE_05 see RULE_23
   assign sr2 = {6'h0, esus_r, 1'b0}; // see RULE_16
   assign in_paused = esus_r && same_sector(addr_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_sh_r <= 8'h0;
         so_r <= 1'b0;
         mem_rd_addr_r <= 32'h0;
      end else if (sck_rise && cnt_r == 7'd7) begin
         unique case ({sh_r[6:0], sync2_r[0]})
            STATUS_ONE_READ_CMD: out_sh_r <= sr1;
            STATUS_TWO_READ_CMD: out_sh_r <= sr2;
            default: out_sh_r <= 8'h0;
         endcase
      end else if (sck_rise && op_r == ARRAY_READ_CMD && cnt_r == abits + 7'd8) begin
         // Data byte is taken one bit late so the address register has settled
         mem_rd_addr_r <= addr_r;
         out_sh_r <= {(in_paused ? UNDEF_DATA[6:0] : mem_rd_data[6:0]), 1'b0}; // see RULE_19
         so_r <= in_paused ? UNDEF_DATA[7] : mem_rd_data[7]; // see RULE_19
      end else if (sck_fall) begin
         so_r <= out_sh_r[7];
         out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
   end
   assign link.so = so_r;

   // ****************************************
   // Protection checks
   // ****************************************
   assign idx = addr_r[16 +: IW];
   assign addr_done = cnt_r == abits + 7'd8; // see RULE_04
   always_comb begin
      if (UNIFORM_256K) begin
         se_prot = range_prot({idx[IW-1:2], 2'h0}) | range_prot({idx[IW-1:2], 2'h1})
                 | range_prot({idx[IW-1:2], 2'h2}) | range_prot({idx[IW-1:2], 2'h3}); // see RULE_11
      end else begin
         se_prot = range_prot(idx) | ((idx < IW'(2)) && (|param_prot_bits[{idx[0], 4'h0} +: 16])); // see RULE_11
      end
      p4_prot = range_prot(idx) | param_prot_bits[addr_r[16:12]];
   end

   // ****************************************
   // Command execution and erase engine
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ENG_IDLE;
         wel_r <= 1'b0;
         eerr_r <= 1'b0;
         perr_r <= 1'b0;
         esus_r <= 1'b0;
         bp_r <= 3'h0;
         bank_reg_r <= 8'h0;
         erase_left_r <= 32'h0;
         prog_left_r <= 32'h0;
         pause_left_r <= 32'h0;
         erase_go_r <= 1'b0;
         erase_kind_r <= 2'h0;
         erase_addr_r <= 32'h0;
         erase_skip_r <= '0;
         erase_done_r <= 1'b0;
         ppb_erase_go_r <= 1'b0;
      end else begin
         erase_go_r <= 1'b0;
         erase_done_r <= 1'b0;
         ppb_erase_go_r <= 1'b0;
         unique case (state_r)
            ENG_ERASE: begin
               erase_left_r <= erase_left_r - 32'h1;
               if (erase_left_r <= 32'h1) begin
                  state_r <= ENG_IDLE;
                  erase_done_r <= 1'b1;
               end
            end
            ENG_PAUSING: begin
               erase_left_r <= erase_left_r - 32'h1;
               pause_left_r <= pause_left_r - 32'h1;
               if (erase_left_r <= 32'h1) begin
                  state_r <= ENG_IDLE; // see RULE_16
                  erase_done_r <= 1'b1;
               end else if (pause_left_r <= 32'h1) begin
                  state_r <= ENG_PAUSED; // see RULE_15 see RULE_16
                  esus_r <= 1'b1;
               end
            end
            ENG_PROG, ENG_PAUSED_PROG: begin
               prog_left_r <= prog_left_r - 32'h1;
               if (prog_left_r <= 32'h1) begin
                  state_r <= (state_r == ENG_PAUSED_PROG) ? ENG_PAUSED : ENG_IDLE; // see RULE_21
               end
            end
            default: begin
            end
         endcase
         if (cs_rise) begin
            unique case (op_r)
               WRITE_ENABLE_CMD: begin
                  if (cnt_r == 7'd8) begin
                     wel_r <= 1'b1;
                  end
               end
               PARAM_SECTOR_ERASE_CMD, PARAM_SECTOR_ERASE_4BYTE_CMD: begin
                  // see RULE_01 see RULE_02 see RULE_24
                  if (!UNIFORM_256K && wel_r && addr_done && state_r == ENG_IDLE && addr_r[31:17] == 15'h0) begin
                     if (p4_prot) begin
                        eerr_r <= 1'b1; // see RULE_06
                        wel_r <= 1'b0;
                     end else begin
                        state_r <= ENG_ERASE; // see RULE_05
                        erase_left_r <= ERASE_CYC;
                        erase_go_r <= 1'b1;
                        erase_kind_r <= KIND_PARAM;
                        erase_addr_r <= {addr_r[31:12], 12'h0};
                        wel_r <= 1'b0;
                     end
                  end // see RULE_07
               end
               SECTOR_ERASE_CMD, SECTOR_ERASE_4BYTE_CMD: begin
                  if (wel_r && addr_done && state_r == ENG_IDLE) begin // see RULE_04 see RULE_24
                     wel_r <= 1'b0;
                     if (se_prot) begin
                        eerr_r <= 1'b1; // see RULE_09
                     end else begin
                        state_r <= ENG_ERASE; // see RULE_05
                        erase_left_r <= ERASE_CYC;
                        erase_go_r <= 1'b1;
                        erase_kind_r <= KIND_SECTOR;
                        erase_addr_r <= UNIFORM_256K ? {addr_r[31:18], 18'h0} : {addr_r[31:16], 16'h0}; // see RULE_10
                     end
                  end
               end
               WHOLE_ARRAY_ERASE_CMD, WHOLE_ARRAY_ERASE_ALT_CMD: begin
                  // see RULE_12 see RULE_13 see RULE_24
                  if (wel_r && cnt_r == 7'd8 && state_r == ENG_IDLE && bp_r == 3'h0) begin
                     state_r <= ENG_ERASE;
                     erase_left_r <= ERASE_CYC;
                     erase_go_r <= 1'b1;
                     erase_kind_r <= KIND_WHOLE;
                     erase_addr_r <= 32'h0;
                     erase_skip_r <= ppb_bits | dyb_bits; // see RULE_14
                     wel_r <= 1'b0;
                  end
               end
               ERASE_PAUSE_CMD: begin
                  if (cnt_r == 7'd8 && state_r == ENG_ERASE && erase_kind_r != KIND_WHOLE) begin
                     state_r <= ENG_PAUSING; // see RULE_15
                     pause_left_r <= SUSPEND_LATENCY_CYC;
                  end
               end
               ERASE_CONTINUE_CMD: begin
                  if (cnt_r == 7'd8 && state_r == ENG_PAUSED) begin // see RULE_17
                     state_r <= ENG_ERASE; // see RULE_18
                     esus_r <= 1'b0;
                  end
               end
               STATUS_CONFIG_WRITE_CMD: begin
                  if (cnt_r == 7'd16 && prev_op_r == BANK_REG_ACCESS_CMD) begin
                     bank_reg_r <= sh_r[7:0]; // see RULE_20
                  end else if (cnt_r == 7'd16 && wel_r && state_r == ENG_IDLE) begin
                     bp_r <= sh_r[BP_LSB +: 3];
                     wel_r <= 1'b0;
                  end
               end
               PERSIST_PROTECT_ERASE_CMD: begin
                  if (cnt_r == 7'd8 && wel_r && state_r == ENG_IDLE) begin // see RULE_20
                     ppb_erase_go_r <= 1'b1;
                     wel_r <= 1'b0;
                  end
               end
               PROGRAM_CMD, PROGRAM_4BYTE_CMD: begin
                  if (wel_r && cnt_r >= abits + 7'd16 && state_r inside {ENG_IDLE, ENG_PAUSED}) begin
                     wel_r <= 1'b0;
                     prog_left_r <= PROG_CYC;
                     if (in_paused) begin
                        perr_r <= 1'b1; // see RULE_21 see RULE_23
                     end else begin
                        state_r <= (state_r == ENG_PAUSED) ? ENG_PAUSED_PROG : ENG_PROG;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= 16'h0;
      end else begin
         status_r <= {sr2, sr1};
      end
   end
endmodule

/* core/flash_host_ctrl.sv */
// Host end: APB registers drive single serial flash command frames
`timescale 1ns/1ns
module flash_host_ctrl #(
   parameter int HALF_CYC = flash_erase_pkg::SCK_HALF_CYC
) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   flash_link_if.host link
);
   import flash_erase_pkg::*;
   if (HALF_CYC < 4) $error("HALF_CYC must be at least 4 to let the device see each edge");

   typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL} host_state_type;
   host_state_type state_r;
   logic [31:0] addr_r;
   logic [7:0] wdata_r, rdata_r;
   logic [12:0] ctrl_r;
   logic [47:0] tx_r;
   logic [5:0] bits_left_r;
   logic [15:0] div_r;
   logic cs_n_r, sck_r, si_r;
   logic [1:0] so_sync_r;
   logic access, start, busy;
   logic [5:0] frame_bits;

   // ****************************************
   // APB slave, no wait states
   // ****************************************
   assign busy = state_r != H_IDLE;
   assign access = psel && penable && pready_r;
   assign start = access && pwrite && paddr[7:0] == CTRL_OFS && !busy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= psel && !penable && !pready_r;
         pslverr_r <= psel && !penable && !(paddr[7:0] inside {CTRL_OFS, ADDR_OFS, WDATA_OFS, STATUS_OFS});
         unique case (paddr[7:0])
            CTRL_OFS: prdata_r <= {19'h0, ctrl_r};
            ADDR_OFS: prdata_r <= addr_r;
            WDATA_OFS: prdata_r <= {24'h0, wdata_r};
            STATUS_OFS: prdata_r <= {16'h0, rdata_r, 7'h0, busy};
            default: prdata_r <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 13'h0;
         addr_r <= 32'h0;
         wdata_r <= 8'h0;
      end else if (access && pwrite && !busy) begin
         unique case (paddr[7:0])
            CTRL_OFS: ctrl_r <= pwdata[12:0];
            ADDR_OFS: addr_r <= pwdata;
            WDATA_OFS: wdata_r <= pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Frame builder and clock divider
   // ****************************************
   always_comb begin
      frame_bits = 6'd8 + {pwdata[CTRL_ABYTES_LSB +: 3], 3'h0};
      if (pwdata[CTRL_WBYTE_POS] || pwdata[CTRL_RBYTE_POS]) begin
         frame_bits = frame_bits + 6'd8;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         so_sync_r <= 2'h0;
      end else begin
         so_sync_r <= {so_sync_r[0], link.so};
      end
   end

   // Chip select rises a half period after the last bit so the device
   // sees the final address or opcode bit before the frame closes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= H_IDLE;
         tx_r <= 48'h0;
         bits_left_r <= 6'h0;
         div_r <= 16'h0;
         cs_n_r <= 1'b1;
         sck_r <= 1'b0;
         si_r <= 1'b0;
         rdata_r <= 8'h0;
      end else begin
         div_r <= (div_r == 16'h0) ? 16'h0 : div_r - 16'h1;
         unique case (state_r)
            H_IDLE: begin
               if (start) begin
                  unique case (pwdata[CTRL_ABYTES_LSB +: 3])
                     3'h4: tx_r <= {pwdata[7:0], addr_r, wdata_r};
                     3'h3: tx_r <= {pwdata[7:0], addr_r[23:0], wdata_r, 8'h0};
                     default: tx_r <= {pwdata[7:0], wdata_r, 32'h0};
                  endcase
                  bits_left_r <= frame_bits;
                  cs_n_r <= 1'b0;
                  div_r <= 16'(HALF_CYC - 1);
                  state_r <= H_LEAD;
               end
            end
            H_LEAD, H_HIGH: begin
               if (div_r == 16'h0) begin
                  sck_r <= 1'b0;
                  if (bits_left_r == 6'h0) begin
                     state_r <= H_TRAIL;
                  end else begin
                     si_r <= tx_r[47];
                     tx_r <= {tx_r[46:0], 1'b0};
                     bits_left_r <= bits_left_r - 6'h1;
                     state_r <= H_LOW;
                  end
                  div_r <= 16'(HALF_CYC - 1);
               end
            end
            H_LOW: begin
               if (div_r == 16'h0) begin
                  sck_r <= 1'b1;
                  rdata_r <= {rdata_r[6:0], so_sync_r[1]};
                  div_r <= 16'(HALF_CYC - 1);
                  state_r <= H_HIGH;
               end
            end
            H_TRAIL: begin
               cs_n_r <= 1'b1;
               if (div_r == 16'h0 && cs_n_r) begin
                  state_r <= H_IDLE;
               end else if (div_r == 16'h0) begin
                  div_r <= 16'(HALF_CYC - 1);
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end
   assign link.cs_n = cs_n_r;
   assign link.sck = sck_r;
   assign link.si = si_r;
endmodule

/* dv/flash_erase_chk.sv */
// Checks on the serial link and the device status around erase starts
`timescale 1ns/1ns
module flash_erase_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic erase_go_r,
   input wire logic [1:0] erase_kind_r,
   input wire logic [15:0] status_r
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sck_idle_low: assert property (cs_n |-> !sck) else $error("sck high outside frame");
   a_si_held: assert property (sck && $past(sck) |-> $stable(si)) else $error("si moved with sck high");
   a_go_after_cs: assert property (erase_go_r |-> cs_n) else $error("erase began inside frame");
   sequence busy_soon;
      ##[1:2] status_r[0];
   endsequence
   a_go_sets_busy: assert property (erase_go_r |-> busy_soon) else $error("busy not shown");
   a_go_one_cycle: assert property (erase_go_r |=> !erase_go_r) else $error("start pulse too long");
   a_go_needs_latch: assert property (erase_go_r |-> $past(status_r[1])) else $error("erase without latch");
   a_whole_bp_zero: assert property (erase_go_r && erase_kind_r == 2'd3 |-> status_r[4:2] == 3'h0)
      else $error("whole erase with protection");
   a_pause_idle: assert property ($rose(status_r[9]) |-> !status_r[0]) else $error("paused but busy");
endmodule

/* dv/test_spi_flash_erase_control.sv */
// Bench driving the host controller over APB against the device end
`timescale 1ns/1ns
module test_spi_flash_erase_control;
   import flash_erase_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, aerr = 0, go, done, pgo, pready, perr;
   logic [31:0] paddr = 0, pwdata = 0, prdata, raddr, eaddr, rd, pprot = 32'h0000_0002;
   logic [7:0] persistent_protect_bit = 0, dynamic_protect_bit = 0, skip;
   logic [1:0] kind;
   logic [15:0] st;
   int seed = 5557, bad_count = 0, samples_checked = 0, cyc = 0;
   logic [33:0] expq[$];
   flash_link_if link();
   flash_erase_device #(.NR(8), .ERASE_CYC(400), .PROG_CYC(20)) u_flash_erase_device (.pclk(pclk),
      .presetn(presetn), .link(link), .ppb_bits(persistent_protect_bit), .dyb_bits(dynamic_protect_bit), .param_prot_bits(pprot),
      .mem_rd_data(8'hff), .mem_rd_addr_r(raddr), .erase_go_r(go), .erase_kind_r(kind), .erase_addr_r(eaddr),
      .erase_skip_r(skip), .erase_done_r(done), .ppb_erase_go_r(pgo), .status_r(st));
   flash_host_ctrl #(.HALF_CYC(4)) u_flash_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata),
      .pready_r(pready), .pslverr_r(perr), .link(link));
   flash_erase_chk u_flash_erase_chk (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .sck(link.sck),
      .si(link.si), .so(link.so), .erase_go_r(go), .erase_kind_r(kind), .status_r(st));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic eq(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data and error are taken at the very edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      aerr = perr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic frame(input logic [7:0] op, input logic [4:0] nb, input logic [31:0] a);
      apb(1, ADDR_OFS, a);
      apb(1, CTRL_OFS, {19'h0, nb, op});
      do apb(0, STATUS_OFS, 0); while (rd[STATUS_BUSY_POS] !== 1'b0);
      repeat (8) @(posedge pclk);
   endtask
   task automatic erase(input logic [7:0] op, input logic [4:0] nb, input logic [31:0] a, input logic [33:0] e);
      frame(WRITE_ENABLE_CMD, 0, 0);
      if (e[33:32] != 2'd0) expq.push_back(e);
      frame(op, nb, a);
      while (st[WIP_POS] !== 1'b0) @(posedge pclk);
   endtask
   // ****************************************
   // Scoreboard: every erase start must match the oldest note
   // ****************************************
   always @(posedge pclk) begin
      if (presetn && go === 1'b1) begin
         if (expq.size() == 0) eq(1, 0);
         else eq({kind, eaddr}, expq.pop_front());
         if (kind == 2'd3) eq(skip, persistent_protect_bit | dynamic_protect_bit);
      end
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      dynamic_protect_bit <= 8'($random(seed)) & 8'hc0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, 8'h10, 0);
      eq(aerr, 1);
      frame(SECTOR_ERASE_CMD, 3, 32'h0001_0000);
      erase(SECTOR_ERASE_CMD, 3, 32'h0001_0123, {2'd2, 32'h0001_0000});
      erase(SECTOR_ERASE_4BYTE_CMD, 4, 32'h0002_0456, {2'd2, 32'h0002_0000});
      erase(PARAM_SECTOR_ERASE_CMD, 3, 32'h0000_2234, {2'd1, 32'h0000_2000});
      erase(PARAM_SECTOR_ERASE_CMD, 3, 32'h0003_0000, 0);
      eq(st[ERASE_ERR_POS], 0);
      erase(PARAM_SECTOR_ERASE_4BYTE_CMD, 4, 32'h0000_1000, 0);
      eq(st[ERASE_ERR_POS], 1);
      persistent_protect_bit <= 8'h02;
      erase(SECTOR_ERASE_CMD, 3, 32'h0001_0000, 0);
      erase(WHOLE_ARRAY_ERASE_CMD, 0, 0, {2'd3, 32'h0});
      erase(WHOLE_ARRAY_ERASE_ALT_CMD, 0, 0, {2'd3, 32'h0});
      frame(WRITE_ENABLE_CMD, 0, 0);
      expq.push_back({2'd2, 32'h0003_0000});
      frame(SECTOR_ERASE_CMD, 3, 32'h0003_0000);
      frame(ERASE_PAUSE_CMD, 0, 0);
      while (st[WIP_POS] !== 1'b0) @(posedge pclk);
      eq(st[8 + ERASE_SUSP_POS], 1);
      frame(ERASE_CONTINUE_CMD, 0, 0);
      eq(st[WIP_POS], 1);
      while (st[WIP_POS] !== 1'b0) @(posedge pclk);
      eq(st[8 + ERASE_SUSP_POS], 0);
      apb(1, WDATA_OFS, 32'h1c);
      frame(WRITE_ENABLE_CMD, 0, 0);
      frame(STATUS_CONFIG_WRITE_CMD, 5'h8, 0);
      erase(WHOLE_ARRAY_ERASE_CMD, 0, 0, 0);
      eq(st[BP_LSB +: 3], 3'h7);
      eq(expq.size(), 0);
      end_of_test();
   end
endmodule
